// file: e1rx_pkg.sv
// constants and types for the e1 receive slip and framer event block
package e1rx_pkg;
   // register addresses on the parallel microprocessor port
   localparam logic [15:0] ADDR_SLIP_STATUS = 16'h0B08;
   localparam logic [15:0] ADDR_SLIP_IRQ_ENABLE = 16'h0B09;
   localparam logic [15:0] ADDR_LOOP_CODE_IRQ_STATUS = 16'h0B0A;
   localparam logic [15:0] ADDR_LOOP_CODE_IRQ_ENABLE = 16'h0B0B;
   // field positions
   localparam int BIT_RX_FULL = 2;
   localparam int BIT_RX_EMPTY = 1;
   localparam int BIT_RX_SLIP = 0;
   localparam int BIT_AUX_STATE = 7;
   localparam int BIT_AUX_CHANGE = 6;
   localparam int BIT_IW_STATE = 5;
   localparam int BIT_IW_CHANGE = 4;
   // reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   // slip buffer holds two frames
   localparam logic [1:0] SB_FRAMES = 2'h2;
   localparam logic [1:0] SB_EMPTY = 2'h0;
   localparam logic [1:0] SB_ONE = 2'h1;
   // interworking wait
   localparam int IW_WAIT_MS = 400;
   localparam int CLK_KHZ = 40000;
   localparam int IW_WAIT_CYC = IW_WAIT_MS * CLK_KHZ;
   localparam int IW_CNT_W = 24;
   // interworking search states, gray along search -> timing -> non-crc
   typedef enum logic [1:0] {
      E1RX_IW_SEARCH = 2'h0,
      E1RX_IW_TIMING = 2'h1,
      E1RX_IW_NONCRC = 2'h3
   } e1rx_iw_state_t;
endpackage : e1rx_pkg

// file: e1rx_slip_ctl.sv
// two-frame receive slip buffer frame pointer control
`timescale 1ns/10ps
module e1rx_slip_ctl (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic wr_frame,
   input wire logic rd_frame,
   output logic full_slip,
   output logic empty_slip,
   output logic wr_frame_sel,
   output logic rd_frame_sel,
   output logic [1:0] frame_count
);
   import e1rx_pkg::*;

   logic next_full_slip;
   logic next_empty_slip;
   logic next_wr_frame_sel;
   logic next_rd_frame_sel;
   logic [1:0] next_frame_count;
   logic is_full;
   logic is_empty;

   // frame accounting; a write and a read together leave the level alone unless the buffer is empty
   always_comb begin
      is_full = (frame_count == SB_FRAMES);
      is_empty = (frame_count == SB_EMPTY);
      next_full_slip = 1'b0;
      next_empty_slip = 1'b0;
      next_wr_frame_sel = wr_frame_sel;
      next_rd_frame_sel = rd_frame_sel;
      next_frame_count = frame_count;
      if (wr_frame && rd_frame && !is_empty) begin
         next_wr_frame_sel = ~wr_frame_sel;
         next_rd_frame_sel = ~rd_frame_sel;
      end else begin
         if (wr_frame) begin
            if (is_full) begin
               // pointer not advanced: the incoming frame is dropped
               next_full_slip = 1'b1;
            end else begin
               next_wr_frame_sel = ~wr_frame_sel;
               next_frame_count = frame_count + SB_ONE;
            end
         end
         if (rd_frame) begin
            if (is_empty) begin
               // pointer held back: the last frame read goes out again
               next_empty_slip = 1'b1;
            end else begin
               next_rd_frame_sel = ~rd_frame_sel;
               next_frame_count = frame_count - SB_ONE;
            end
         end
      end
   end

   // register the pointers and slip pulses
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         full_slip <= 1'b0;
         empty_slip <= 1'b0;
         wr_frame_sel <= 1'b0;
         rd_frame_sel <= 1'b0;
         frame_count <= SB_EMPTY;
      end else if (ce) begin
         full_slip <= next_full_slip;
         empty_slip <= next_empty_slip;
         wr_frame_sel <= next_wr_frame_sel;
         rd_frame_sel <= next_rd_frame_sel;
         frame_count <= next_frame_count;
      end
   end
endmodule : e1rx_slip_ctl

// file: e1rx_event_irq.sv
// e1 receive slip and framer event registers with interrupt request
// Behaviour
// - a write into a full slip buffer drops one frame and sets rx full.
// - a read from an empty slip buffer repeats one frame, sets rx empty.
// - slip enable bit 2, reset zero, gates the rx full interrupt.
// - slip enable bit 1, reset zero, gates the rx empty interrupt.
// - slip enable bit 0, reset zero, gates the combined rx slip interrupt.
// - loop status bit 7 reads one while the 101010 pattern is detected.
// - when enabled, bit 6 flags both start and end of the aux pattern.
// - the aux change flag resets to zero and clears on a host read.
// - loop status bit 5 is the interworking state while annex b is enabled, reset zero.
// - no crc-4 multiframe lock 400 ms after frame lock sets interworking.
// - with annex b and crc-4 alignment enabled the framer runs the annex b crc-4 search.
// - loop status bit 4 is set on entry to or exit from interworking.
// - loop enable bit 6, reset zero, enables the aux change interrupt.
// - loop enable bit 4, reset zero, enables the interworking interrupt.
`timescale 1ns/10ps
module e1rx_event_irq #(
   parameter int IW_WAIT = e1rx_pkg::IW_WAIT_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sb_wr_frame,
   input wire logic sb_rd_frame,
   output logic sb_wr_frame_sel,
   output logic sb_rd_frame_sel,
   input wire logic aux_pattern_detect,
   input wire logic crc4_align_en,
   input wire logic annex_b_alignment_en,
   input wire logic basic_frame_aligned,
   input wire logic crc4_mf_aligned,
   output logic annex_b_search,
   output logic irq
);
   import e1rx_pkg::*;

   // register address decode for reads and writes
   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      hit = (a == b);
   endfunction : hit

   // set wins over a clear in the same cycle
   function automatic logic sticky(input logic q, input logic set,
                                   input logic clr);
      sticky = set | (q & ~clr);
   endfunction : sticky

   logic full_slip;
   logic empty_slip;
   logic [1:0] sb_level;
   logic [2:0] slip_irq_enable;
   logic [2:0] next_slip_irq_enable;
   logic [2:0] slip_status;
   logic [2:0] next_slip_status;
   logic aux_pattern_change_en;
   logic next_aux_pattern_change_en;
   logic interwork_change_en;
   logic next_interwork_change_en;
   logic aux_pattern_state;
   logic next_aux_pattern_state;
   logic aux_pattern_change_flag;
   logic next_aux_pattern_change_flag;
   logic interwork_change_flag;
   logic next_interwork_change_flag;
   e1rx_iw_state_t iw_state;
   e1rx_iw_state_t next_iw_state;
   logic [IW_CNT_W-1:0] iw_cnt;
   logic [IW_CNT_W-1:0] next_iw_cnt;
   logic [7:0] next_reg_rdata;
   logic next_irq;
   logic next_annex_b_search;
   logic rd_slip;
   logic rd_loop;
   logic iw_enter;
   logic iw_leave;
   logic aux_edge;

   // frame pointer control of the two-frame slip buffer
   e1rx_slip_ctl u_slip (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .wr_frame(sb_wr_frame),
      .rd_frame(sb_rd_frame),
      .full_slip(full_slip),
      .empty_slip(empty_slip),
      .wr_frame_sel(sb_wr_frame_sel),
      .rd_frame_sel(sb_rd_frame_sel),
      .frame_count(sb_level)
   );

   // interworking search; loss of frame lock or gain of crc-4 lock ends the wait
   always_comb begin
      next_iw_state = iw_state;
      next_iw_cnt = iw_cnt;
      iw_enter = 1'b0;
      iw_leave = 1'b0;
      unique case (iw_state)
         E1RX_IW_SEARCH: begin
            next_iw_cnt = '0;
            if (crc4_align_en && basic_frame_aligned && !crc4_mf_aligned) begin
               next_iw_state = E1RX_IW_TIMING;
            end
         end
         E1RX_IW_TIMING: begin
            if (!crc4_align_en || !basic_frame_aligned || crc4_mf_aligned) begin
               next_iw_state = E1RX_IW_SEARCH;
            end else if (iw_cnt == IW_CNT_W'(IW_WAIT - 1)) begin
               next_iw_state = E1RX_IW_NONCRC;
               iw_enter = 1'b1;
            end else begin
               next_iw_cnt = iw_cnt + IW_CNT_W'(1);
            end
         end
         E1RX_IW_NONCRC: begin
            // far end found to send crc-4 after all, or crc-4 alignment disabled
            if (!crc4_align_en || crc4_mf_aligned) begin
               next_iw_state = E1RX_IW_SEARCH;
               iw_leave = 1'b1;
            end
         end
         default: begin
            next_iw_state = E1RX_IW_SEARCH;
         end
      endcase
   end

   // interworking state registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         iw_state <= E1RX_IW_SEARCH;
         iw_cnt <= '0;
      end else if (ce) begin
         iw_state <= next_iw_state;
         iw_cnt <= next_iw_cnt;
      end
   end

   // host register writes, status flags and read data
   always_comb begin
      rd_slip = reg_rd && hit(reg_addr, ADDR_SLIP_STATUS);
      rd_loop = reg_rd && hit(reg_addr, ADDR_LOOP_CODE_IRQ_STATUS);
      aux_edge = aux_pattern_detect ^ aux_pattern_state;
      next_aux_pattern_state = aux_pattern_detect;
      next_slip_irq_enable = slip_irq_enable;
      next_aux_pattern_change_en = aux_pattern_change_en;
      next_interwork_change_en = interwork_change_en;
      if (reg_wr && hit(reg_addr, ADDR_SLIP_IRQ_ENABLE)) begin
         next_slip_irq_enable[BIT_RX_FULL] = reg_wdata[BIT_RX_FULL];
         next_slip_irq_enable[BIT_RX_EMPTY] = reg_wdata[BIT_RX_EMPTY];
         next_slip_irq_enable[BIT_RX_SLIP] = reg_wdata[BIT_RX_SLIP];
      end
      if (reg_wr && hit(reg_addr, ADDR_LOOP_CODE_IRQ_ENABLE)) begin
         next_aux_pattern_change_en = reg_wdata[BIT_AUX_CHANGE];
         next_interwork_change_en = reg_wdata[BIT_IW_CHANGE];
      end
      next_slip_status[BIT_RX_FULL] =
         sticky(slip_status[BIT_RX_FULL], full_slip, rd_slip);
      next_slip_status[BIT_RX_EMPTY] =
         sticky(slip_status[BIT_RX_EMPTY], empty_slip, rd_slip);
      next_slip_status[BIT_RX_SLIP] = sticky(slip_status[BIT_RX_SLIP],
         full_slip | empty_slip, rd_slip);
      next_aux_pattern_change_flag = sticky(aux_pattern_change_flag,
         aux_edge & aux_pattern_change_en, rd_loop);
      next_interwork_change_flag = sticky(interwork_change_flag,
         iw_enter | iw_leave, rd_loop);
      // read data; unmapped addresses read zero
      next_reg_rdata = REG_RESET;
      if (hit(reg_addr, ADDR_SLIP_STATUS)) begin
         next_reg_rdata[2:0] = slip_status;
      end else if (hit(reg_addr, ADDR_SLIP_IRQ_ENABLE)) begin
         next_reg_rdata[2:0] = slip_irq_enable;
      end else if (hit(reg_addr, ADDR_LOOP_CODE_IRQ_STATUS)) begin
         next_reg_rdata[BIT_AUX_STATE] = aux_pattern_state;
         next_reg_rdata[BIT_AUX_CHANGE] = aux_pattern_change_flag;
         next_reg_rdata[BIT_IW_STATE] =
            (iw_state == E1RX_IW_NONCRC) && annex_b_alignment_en;
         next_reg_rdata[BIT_IW_CHANGE] = interwork_change_flag;
      end else if (hit(reg_addr, ADDR_LOOP_CODE_IRQ_ENABLE)) begin
         next_reg_rdata[BIT_AUX_CHANGE] = aux_pattern_change_en;
         next_reg_rdata[BIT_IW_CHANGE] = interwork_change_en;
      end
      // request only while an enabled flag stands
      next_irq = |(next_slip_status & next_slip_irq_enable)
         | (next_aux_pattern_change_flag & next_aux_pattern_change_en)
         | (next_interwork_change_flag & next_interwork_change_en);
      next_annex_b_search = annex_b_alignment_en & crc4_align_en;
   end

   // register block state; read data is held until the next read
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         slip_irq_enable <= REG_RESET[2:0];
         slip_status <= REG_RESET[2:0];
         aux_pattern_change_en <= 1'b0;
         interwork_change_en <= 1'b0;
         aux_pattern_state <= 1'b0;
         aux_pattern_change_flag <= 1'b0;
         interwork_change_flag <= 1'b0;
         reg_rdata <= REG_RESET;
         irq <= 1'b0;
         annex_b_search <= 1'b0;
      end else if (ce) begin
         slip_irq_enable <= next_slip_irq_enable;
         slip_status <= next_slip_status;
         aux_pattern_change_en <= next_aux_pattern_change_en;
         interwork_change_en <= next_interwork_change_en;
         aux_pattern_state <= next_aux_pattern_state;
         aux_pattern_change_flag <= next_aux_pattern_change_flag;
         interwork_change_flag <= next_interwork_change_flag;
         if (reg_rd) begin
            reg_rdata <= next_reg_rdata;
         end
         irq <= next_irq;
         annex_b_search <= next_annex_b_search;
      end
   end
endmodule : e1rx_event_irq

// file: e1rx_event_irq_props.sv
// port assertions for the e1 receive event register block
`timescale 1ns/10ps
module e1rx_event_irq_props import e1rx_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [15:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic aux_pattern_detect,
   input wire logic crc4_align_en,
   input wire logic annex_b_alignment_en,
   input wire logic annex_b_search
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // a read taken at one address
   sequence s_rd(a);
      ce && reg_rd && reg_addr == a;
   endsequence
   // pattern held steady before the read is taken
   sequence s_aux_rd;
      aux_pattern_detect [*3] ##0 s_rd(ADDR_LOOP_CODE_IRQ_STATUS);
   endsequence
   sequence s_no_annex_rd;
      !annex_b_alignment_en [*2] ##0 s_rd(ADDR_LOOP_CODE_IRQ_STATUS);
   endsequence
   a_rdata_holds: assert property (
      !(ce && reg_rd) |=> $stable(reg_rdata)) else $error("rdata moved");
   a_annex_b_follows: assert property (ce |=>
      annex_b_search == $past(annex_b_alignment_en && crc4_align_en))
      else $error("annex b search wrong");
   a_unmapped_zero: assert property (ce && reg_rd &&
      (reg_addr < ADDR_SLIP_STATUS || reg_addr > ADDR_LOOP_CODE_IRQ_ENABLE)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_slip_en_bits: assert property (
      s_rd(ADDR_SLIP_IRQ_ENABLE) |=> reg_rdata[7:3] == 5'h00)
      else $error("slip enable reserved bits set");
   a_loop_en_bits: assert property (
      s_rd(ADDR_LOOP_CODE_IRQ_ENABLE) |=> (reg_rdata & 8'hAF) == 8'h00)
      else $error("loop enable reserved bits set");
   a_loop_stat_bits: assert property (
      s_rd(ADDR_LOOP_CODE_IRQ_STATUS) |=> reg_rdata[3:0] == 4'h0)
      else $error("loop status low bits set");
   a_slip_stat_bits: assert property (
      s_rd(ADDR_SLIP_STATUS) |=> reg_rdata[7:3] == 5'h00)
      else $error("slip status reserved bits set");
   a_aux_state_read: assert property (
      s_aux_rd |=> reg_rdata[7]) else $error("aux state not shown");
   a_iw_needs_annex: assert property (
      s_no_annex_rd |=> !reg_rdata[5]) else $error("iw state without annex");
endmodule : e1rx_event_irq_props
bind e1rx_event_irq e1rx_event_irq_props u_props (.clk(clk), .rst_b(rst_b),
   .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .aux_pattern_detect(aux_pattern_detect), .crc4_align_en(crc4_align_en),
   .annex_b_alignment_en(annex_b_alignment_en),
   .annex_b_search(annex_b_search));

// file: e1rx_host_model.sv
// host software model on the parallel register port
`timescale 1ns/10ps
module e1rx_host_model (
   input wire logic clk,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // idle bus; strobes low so nothing is taken
   initial begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // a spare cycle after each strobe keeps two drives out of one step
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #2;
      reg_wr = 1'b0;
      @(posedge clk);
      #2;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #2;
      reg_rd = 1'b0;
      d = reg_rdata; // a loop status read clears the change flags
      @(posedge clk);
      #2;
   endtask : rd
endmodule : e1rx_host_model

// file: e1rx_event_irq_bench.sv
// self-checking bench for the e1 receive event block
`timescale 1ns/10ps
module e1rx_event_irq_bench;
   import e1rx_pkg::*;
   localparam int IW = 20;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic sb_wr_frame = 1'b0, sb_rd_frame = 1'b0, aux = 1'b0;
   logic crc4 = 1'b0, annex_b = 1'b0, bfa = 1'b0, mfa = 1'b0;
   logic reg_wr, reg_rd, irq, annex_b_search, wr_sel, rd_sel;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   int fails = 0;
   int samples_checked = 0;
   always #12.5 clk = ~clk;
   e1rx_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   e1rx_event_irq #(.IW_WAIT(IW)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sb_wr_frame(sb_wr_frame), .sb_rd_frame(sb_rd_frame),
      .sb_wr_frame_sel(wr_sel), .sb_rd_frame_sel(rd_sel),
      .aux_pattern_detect(aux), .crc4_align_en(crc4),
      .annex_b_alignment_en(annex_b), .basic_frame_aligned(bfa),
      .crc4_mf_aligned(mfa), .annex_b_search(annex_b_search), .irq(irq));
   // inputs always move 2 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic check(input string nm, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // one frame start pulse, then time for the flag to land
   task automatic frame(input bit w);
      if (w) sb_wr_frame = 1'b1;
      else sb_rd_frame = 1'b1;
      cyc(1);
      sb_wr_frame = 1'b0;
      sb_rd_frame = 1'b0;
      cyc(3);
   endtask : frame
   task automatic t_reset;
      for (int i = 8; i < 13; i++) begin
         host.rd(16'h0B00 + 16'(i), d);
         check("reset read", d, REG_RESET);
      end
      check("reset irq", irq, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_enables;
      host.wr(ADDR_SLIP_IRQ_ENABLE, 8'hFF);
      host.wr(ADDR_LOOP_CODE_IRQ_ENABLE, 8'hFF);
      host.wr(16'h0B0C, 8'hFF);
      host.rd(ADDR_SLIP_IRQ_ENABLE, d);
      check("slip enable", d, 8'h07);
      host.rd(ADDR_LOOP_CODE_IRQ_ENABLE, d);
      check("loop enable", d, 8'h50);
      host.rd(16'h0B0C, d);
      check("unmapped", d, 8'h00);
      host.wr(ADDR_LOOP_CODE_IRQ_ENABLE, 8'h00);
      $display("test enables done");
   endtask : t_enables
   task automatic t_slip;
      host.wr(ADDR_SLIP_IRQ_ENABLE, 8'h04);
      frame(1'b0);
      check("empty masked irq", irq, 1'b0);
      check("empty repeat sel", rd_sel, 1'b0);
      host.rd(ADDR_SLIP_STATUS, d);
      check("empty slip", d, 8'h03);
      repeat (3) frame(1'b1);
      check("full irq", irq, 1'b1);
      check("full drop sel", wr_sel, 1'b0);
      host.rd(ADDR_SLIP_STATUS, d);
      check("full slip", d, 8'h05);
      check("irq after read", irq, 1'b0);
      host.wr(ADDR_SLIP_IRQ_ENABLE, 8'h01);
      repeat (3) frame(1'b0);
      check("slip irq", irq, 1'b1);
      check("read repeat sel", rd_sel, 1'b0);
      host.rd(ADDR_SLIP_STATUS, d);
      host.wr(ADDR_SLIP_IRQ_ENABLE, 8'h00);
      $display("test slip done");
   endtask : t_slip
   task automatic t_aux;
      aux = 1'b1;
      cyc(4);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("aux masked", d, 8'h80);
      host.wr(ADDR_LOOP_CODE_IRQ_ENABLE, 8'h40);
      aux = 1'b0;
      cyc(4);
      check("aux irq", irq, 1'b1);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("aux end", d, 8'h40);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("aux cleared", d, 8'h00);
      aux = 1'b1;
      cyc(4);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("aux start", d, 8'hC0);
      $display("test aux done");
   endtask : t_aux
   task automatic t_iw;
      host.wr(ADDR_LOOP_CODE_IRQ_ENABLE, 8'h10);
      crc4 = 1'b1;
      annex_b = 1'b1;
      bfa = 1'b1;
      cyc(IW - 4);
      check("iw early", irq, 1'b0);
      cyc(10);
      check("iw irq", irq, 1'b1);
      check("annex b search", annex_b_search, 1'b1);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("iw entry", d, 8'hB0);
      annex_b = 1'b0;
      cyc(2);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("iw hidden", d, 8'h80);
      mfa = 1'b1;
      cyc(4);
      host.rd(ADDR_LOOP_CODE_IRQ_STATUS, d);
      check("iw exit", d, 8'h90);
      $display("test interworking done");
   endtask : t_iw
   // with ce low neither a register write nor a frame pulse may land
   task automatic t_freeze;
      ce = 1'b0;
      host.wr(ADDR_SLIP_IRQ_ENABLE, 8'h07);
      frame(1'b1);
      ce = 1'b1;
      host.rd(ADDR_SLIP_IRQ_ENABLE, d);
      check("frozen enable", d, 8'h00);
      check("frozen write sel", wr_sel, 1'b0);
      host.rd(ADDR_SLIP_STATUS, d);
      check("frozen slip status", d, 8'h00);
      $display("test clock enable done");
   endtask : t_freeze
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   // reset held 16 cycles, then the scenarios in turn
   initial begin
      cyc(16);
      rst_b = 1'b1;
      cyc(1);
      t_reset;
      t_enables;
      t_slip;
      t_aux;
      t_iw;
      t_freeze;
      final_report;
   end
endmodule : e1rx_event_irq_bench
